// file: core/fpm_attr.sv
// One attribute's interval, failure and history counters.
`timescale 1ns/1ps
`default_nettype none
module fpm_attr
	import fpm_pkg::*;
#(
	parameter int unsigned INTERVAL = INTERVAL_LEN,
	parameter int unsigned ERR_MAX = ERR_THRESH,
	parameter int unsigned PRED_MAX = PRED_THRESH
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Events.
	input wire logic enable,
	input wire logic op_done,
	input wire logic op_error,
	// Result.
	output logic predict
);
	localparam int IW = $clog2(INTERVAL + 1);
	localparam int EW = $clog2(ERR_MAX + 2);
	localparam int HW = $clog2(PRED_MAX + 1);
	initial begin
		if (INTERVAL < 1 || PRED_MAX < 1) $error("fpm_attr: bad constants");
	end
	logic [IW-1:0] op_cnt; // R16
	logic [EW-1:0] err_cnt;
	logic [HW-1:0] hist;
	logic bad, good;
	// Judgement: too many errors early, or interval end.
	assign bad = enable && (err_cnt > EW'(ERR_MAX)); // R12
	assign good = enable && !bad && (op_cnt == IW'(INTERVAL)); // R10 R12
	// Interval and failure counters, cleared on each judgement.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || bad || good) begin // R13
			op_cnt <= '0;
			err_cnt <= '0;
		end else if (enable && op_done) begin // R2
			op_cnt <= op_cnt + IW'(1); // R10
			if (op_error) begin
				err_cnt <= err_cnt + EW'(1); // R11
			end
		end
	end
	// History counter saturating at zero and at the threshold.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hist <= '0;
		end else if (bad && hist != HW'(PRED_MAX)) begin
			hist <= hist + HW'(1); // R14
		end else if (good && hist != '0) begin
			hist <= hist - HW'(1); // R14
		end
	end
	assign predict = (hist == HW'(PRED_MAX)); // R15
	a_hist_floor: assert property (@(posedge clk_sys) disable iff (sys_rst) // R14
		good && hist == '0 |=> hist == '0) else $error("history underflow");
	a_judge_clear: assert property (@(posedge clk_sys) disable iff (sys_rst) // R13
		bad |=> op_cnt == '0 && err_cnt == '0) else $error("counters not cleared");
endmodule // fpm_attr
`default_nettype wire

// file: core/fpm_monitor.sv
// Failure prediction monitor top: attributes, scheduler and reporting.
`timescale 1ns/1ps
`default_nettype none
module fpm_monitor
	import fpm_pkg::*;
#(
	parameter int unsigned PERIOD_S = SCHED_PERIOD_S,
	parameter int unsigned SEC_CNT = SEC_CYCLES,
	parameter int unsigned ONLINE_CNT = ONLINE_PASS_CYCLES,
	parameter int unsigned FULL_CNT = FULL_PASS_CYCLES
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Control bits.
	input wire logic prediction_disable,
	input wire logic online_only_select,
	input wire logic [3:0] report_method,
	// Commands and bus state.
	input wire logic rezero_cmd,
	input wire logic bus_idle,
	input wire logic [NUM_ATTR-1:0] op_done,
	input wire logic [NUM_ATTR-1:0] op_error,
	// Persistent code store.
	input wire logic nv_code_valid,
	input wire logic sense_taken,
	// Status.
	output logic [12:0] time_left_s,
	output logic pass_busy,
	output logic pass_online,
	output logic failure_pending,
	output logic [23:0] sense_code,
	output logic sense_valid
);
	initial begin
		if (PERIOD_S < 1 || PERIOD_S > 8191 || SEC_CNT < 1 || ONLINE_CNT < 1 || FULL_CNT < 1)
			$error("fpm_monitor: bad timing parameters");
	end
	// ----------------------------------------
	// Attributes
	// ----------------------------------------
	logic [NUM_ATTR-1:0] predict;
	logic enabled;
	assign enabled = !prediction_disable; // R1
	genvar gi;
	generate
		for (gi = 0; gi < NUM_ATTR; gi++) begin : g_attr
			fpm_attr #(.INTERVAL(INTERVAL_LEN), .ERR_MAX(ERR_THRESH),
				.PRED_MAX(PRED_THRESH)) u_attr (
				.clk_sys(clk_sys),
				.sys_rst(sys_rst),
				.enable(enabled),
				.op_done(op_done[gi]),
				.op_error(op_error[gi]),
				.predict(predict[gi])
			);
		end
	endgenerate
	// ----------------------------------------
	// Scheduler
	// ----------------------------------------
	fpm_state_t state;
	logic [31:0] sec_div;
	logic [31:0] pass_cnt;
	logic sec_tick;
	logic force_req;
	logic offline_ok;
	assign sec_tick = (sec_div == SEC_CNT - 1);
	assign offline_ok = enabled && !online_only_select; // R3
	// One-second enable pulse.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || sec_tick) begin
			sec_div <= '0;
		end else begin
			sec_div <= sec_div + 32'h1;
		end
	end
	// Remembers a rezero that arrives during a pass.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !enabled) begin
			force_req <= 1'b0;
		end else if (rezero_cmd && state == FPM_PASS) begin
			force_req <= 1'b1;
		end else if (state != FPM_PASS) begin
			force_req <= 1'b0;
		end
	end
	// Pass sequencing and countdown timer.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= FPM_IDLE;
			time_left_s <= 13'(PERIOD_S);
			pass_cnt <= '0;
			pass_online <= 1'b0;
		end else if (!enabled && state != FPM_PASS) begin // R1
			state <= FPM_IDLE;
			time_left_s <= 13'(PERIOD_S);
		end else begin
			case (state)
				FPM_IDLE: begin
					if (rezero_cmd) begin // R4
						state <= FPM_PASS;
						pass_online <= !offline_ok;
						pass_cnt <= offline_ok ? 32'(FULL_CNT) : 32'(ONLINE_CNT);
						time_left_s <= 13'(PERIOD_S);
					end else if (sec_tick) begin
						if (time_left_s <= 13'h1) begin
							state <= FPM_WAIT_IDLE;
							time_left_s <= 13'h0;
						end else begin
							time_left_s <= time_left_s - 13'h1; // R5
						end
					end
				end
				FPM_WAIT_IDLE: begin
					if (rezero_cmd || bus_idle) begin // R6
						state <= FPM_PASS;
						pass_online <= !offline_ok;
						pass_cnt <= offline_ok ? 32'(FULL_CNT) : 32'(ONLINE_CNT); // R7
						time_left_s <= 13'(PERIOD_S); // R4
					end
				end
				FPM_PASS: begin
					if (pass_cnt <= 32'h1) begin // R7
						state <= force_req ? FPM_WAIT_IDLE : FPM_IDLE;
						pass_cnt <= '0;
					end else begin
						pass_cnt <= pass_cnt - 32'h1;
					end
				end
				default: state <= FPM_IDLE;
			endcase
		end
	end
	assign pass_busy = (state == FPM_PASS);
	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	// Pending code is loaded from the persistent store and held until taken.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			failure_pending <= 1'b0;
		end else if (nv_code_valid || (enabled && |predict)) begin // R15 R9
			failure_pending <= 1'b1;
		end else if (sense_taken && sense_valid) begin
			failure_pending <= 1'b0;
		end
	end
	// Sense code output gated by the reporting method.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sense_code <= 24'h0;
			sense_valid <= 1'b0;
		end else begin
			sense_valid <= failure_pending && enabled && report_method != REPORT_NONE; // R8 R1
			sense_code <= SENSE_PREDICT;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_pass_len_full: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
		$rose(pass_busy) && !pass_online |-> pass_cnt <= 32'(FULL_CNT))
		else $error("full pass too long");
	a_online_len: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
		$rose(pass_busy) && pass_online |-> pass_cnt <= 32'(ONLINE_CNT))
		else $error("online pass too long");
	a_online_mode: assert property (@(posedge clk_sys) disable iff (sys_rst) // R3
		$rose(pass_busy) |-> pass_online == $past(online_only_select))
		else $error("online-only ignored");
	a_rezero_timer: assert property (@(posedge clk_sys) disable iff (sys_rst) // R4
		rezero_cmd && enabled && state != FPM_PASS |=> pass_busy && time_left_s == 13'(PERIOD_S))
		else $error("rezero did not force pass");
	a_wait_idle: assert property (@(posedge clk_sys) disable iff (sys_rst) // R6
		state == FPM_WAIT_IDLE && !bus_idle && !rezero_cmd && enabled |=> !pass_busy)
		else $error("pass started on busy bus");
	a_disable_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
		prediction_disable |=> !sense_valid) else $error("report while disabled");
	a_pending_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // R9
		failure_pending && !sense_taken |=> failure_pending) else $error("code lost");
	a_report_code: assert property (@(posedge clk_sys) disable iff (sys_rst) // R8
		failure_pending && enabled && report_method != REPORT_NONE |=> sense_valid)
		else $error("code not posted");
	c_pass_full: cover property (@(posedge clk_sys) $rose(pass_busy) && !pass_online);
	c_pass_online: cover property (@(posedge clk_sys) $rose(pass_busy) && pass_online);
	c_predict: cover property (@(posedge clk_sys) $rose(failure_pending));
endmodule // fpm_monitor
`default_nettype wire

// file: core/fpm_pkg.sv
// Package of constants for the failure prediction monitor.
// Behaviour
// R1: Disable bit suspends collection, passes and reporting.
// R2: Enabled monitor collects data during media operations.
// R3: Online-only mode skips all off-line measurement.
// R4: Rezero forces pass and restarts two-hour timer; after a rezero during a pass, the next pass still waits for bus idle.
// R5: Remaining time to next pass is readable.
// R6: Scheduled pass every two hours when bus idle.
// R7: Pass uninterrupted; 60 ms or 370 ms maximum.
// R8: Predictive failure posts sense code per reporting method.
// R9: Posted code persists until reported.
// R10: Interval counter counts operations to interval length.
// R11: Failure counter counts errors in interval.
// R12: Errors above threshold mean unacceptable, else acceptable.
// R13: Judgement clears interval and failure counters.
// R14: History counter up on bad, down on good, floor zero.
// R15: History reaching predictive threshold signals failure.
// R16: Thresholds are per-attribute constants, counters wide enough.
package fpm_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned SCHED_PERIOD_S = 7200;
	localparam int unsigned PASS_ONLINE_MS = 60;
	localparam int unsigned PASS_FULL_MS = 370;
	localparam int unsigned SEC_CYCLES = CLK_HZ;
	localparam int unsigned ONLINE_PASS_CYCLES = CLK_HZ / 1000 * PASS_ONLINE_MS;
	localparam int unsigned FULL_PASS_CYCLES = CLK_HZ / 1000 * PASS_FULL_MS;
	// ----------------------------------------
	// Per-attribute judgement constants
	// ----------------------------------------
	localparam int unsigned NUM_ATTR = 4;
	localparam int unsigned INTERVAL_LEN = 1000;
	localparam int unsigned ERR_THRESH = 10;
	localparam int unsigned PRED_THRESH = 8;
	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	localparam logic [23:0] SENSE_PREDICT = 24'h015d00;
	localparam logic [3:0] REPORT_NONE = 4'h0;
	typedef enum logic [1:0] {FPM_IDLE, FPM_WAIT_IDLE, FPM_PASS} fpm_state_t;
endpackage

// file: testbench/fpm_host.sv
// Host model: drives the bus idle state and takes posted sense reports.
`timescale 1ns/1ps
`default_nettype none
module fpm_host (
	// Clock.
	input wire logic clk_sys,
	// Bench control.
	input wire logic idle_req,
	// Device side.
	input wire logic sense_valid,
	output logic bus_idle,
	output logic sense_taken
);
	logic [1:0] wait_cnt;
	// A slow host that starts with a busy bus and takes a report three cycles after it is posted.
	initial begin
		bus_idle = 1'b0;
		sense_taken = 1'b0;
		wait_cnt = 2'h0;
		forever begin
			@(posedge clk_sys);
			#1;
			bus_idle = idle_req;
			sense_taken = sense_valid && (wait_cnt == 2'h3);
			wait_cnt = sense_valid ? wait_cnt + 2'h1 : 2'h0;
		end
	end
endmodule // fpm_host
`default_nettype wire

// file: testbench/fpm_monitor_tb.sv
// Self-checking testbench of the failure prediction monitor.
`timescale 1ns/1ps
`default_nettype none
module fpm_monitor_tb;
	import fpm_pkg::*;
	logic clk_sys, sys_rst, prediction_disable, online_only_select, rezero_cmd, nv_code_valid;
	logic idle_req, bus_idle, sense_taken, pass_busy, pass_online, failure_pending, sense_valid;
	logic [3:0] report_method, op_done, op_error;
	logic [12:0] time_left_s;
	logic [23:0] sense_code;
	int n_mismatch = 0;
	int cmp_count = 0;
	int k;
	// Short timing: 3 s period, 10-cycle seconds, 20/5-cycle passes.
	fpm_monitor #(.PERIOD_S(3), .SEC_CNT(10), .ONLINE_CNT(5), .FULL_CNT(20)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .prediction_disable(prediction_disable),
		.online_only_select(online_only_select), .report_method(report_method),
		.rezero_cmd(rezero_cmd), .bus_idle(bus_idle), .op_done(op_done), .op_error(op_error),
		.nv_code_valid(nv_code_valid), .sense_taken(sense_taken), .time_left_s(time_left_s),
		.pass_busy(pass_busy), .pass_online(pass_online), .failure_pending(failure_pending),
		.sense_code(sense_code), .sense_valid(sense_valid));
	fpm_host host (.clk_sys(clk_sys), .idle_req(idle_req), .sense_valid(sense_valid),
		.bus_idle(bus_idle), .sense_taken(sense_taken));
	// Clock of 25 ns.
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Waits n edges, then steps just past the edge.
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	// Compares one value and reports a mismatch.
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Holds reset for 20 cycles.
	task automatic restart();
		sys_rst = 1'b1;
		tick(20);
		sys_rst = 1'b0;
	endtask
	// Runs n back-to-back operations on attribute 0, then leaves one quiet cycle.
	// The quiet cycle is the judgement edge, so no operation is lost to the counter clear.
	task automatic ops(input int n, input logic err);
		op_done = 4'h1;
		op_error = {3'h0, err};
		tick(n);
		op_done = 4'h0;
		op_error = 4'h0;
		tick(1);
	endtask
	// Forces a pass and measures how long it stands.
	task automatic pass_len(input int exp_len, input logic exp_online);
		int len;
		len = 0;
		rezero_cmd = 1'b1;
		tick(1);
		rezero_cmd = 1'b0;
		if (exp_len > 0) begin
			check(time_left_s, 24'h3);
			check(pass_online, exp_online);
		end
		while (pass_busy === 1'b1 && len < 1000) begin
			len++;
			tick(1);
		end
		check(24'(len), 24'(exp_len));
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Watchdog far beyond the roughly 1400 cycles the tests need.
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		$display("watchdog expired");
		complete_run();
	end
	// Test sequence.
	initial begin
		sys_rst = 1'b1;
		prediction_disable = 1'b0;
		online_only_select = 1'b0;
		report_method = 4'h1;
		rezero_cmd = 1'b0;
		op_done = 4'h0;
		op_error = 4'h0;
		nv_code_valid = 1'b0;
		idle_req = 1'b0;
		restart();
		check(time_left_s, 24'h3);
		check(pass_busy, 24'h0);
		pass_len(20, 1'b0);
		online_only_select = 1'b1;
		pass_len(5, 1'b1);
		online_only_select = 1'b0;
		$display("test forced passes done");
		prediction_disable = 1'b1;
		pass_len(0, 1'b0);
		for (k = 0; k < 9; k++) ops(11, 1'b1);
		tick(3);
		check(failure_pending, 24'h0);
		prediction_disable = 1'b0;
		$display("test disable done");
		restart();
		tick(15);
		check(time_left_s, 24'h2);
		tick(25);
		check(pass_busy, 24'h0);
		idle_req = 1'b1;
		k = 0;
		while (pass_busy !== 1'b1 && k < 5) begin
			k++;
			tick(1);
		end
		check(pass_busy, 24'h1);
		idle_req = 1'b0;
		$display("test scheduled pass done");
		restart();
		for (k = 0; k < 7; k++) ops(11, 1'b1);
		ops(10, 1'b1);
		ops(990, 1'b0);
		ops(11, 1'b1);
		tick(3);
		check(failure_pending, 24'h0);
		ops(10, 1'b1);
		tick(3);
		check(failure_pending, 24'h0);
		ops(1, 1'b1);
		tick(2);
		check(failure_pending, 24'h1);
		tick(1);
		check(sense_valid, 24'h1);
		check(sense_code, 24'h015d00);
		$display("test judgement done");
		restart();
		report_method = 4'h0;
		nv_code_valid = 1'b1;
		tick(1);
		nv_code_valid = 1'b0;
		tick(3);
		check(failure_pending, 24'h1);
		check(sense_valid, 24'h0);
		report_method = 4'h1;
		tick(3);
		check(sense_valid, 24'h1);
		tick(8);
		check(failure_pending, 24'h0);
		$display("test persistence done");
		complete_run();
	end
endmodule // fpm_monitor_tb
`default_nettype wire
